// *** ovuv_reaction_regs.vh ***
// Constants for the output over/undervoltage fault reaction block.
// Assumes the configuration bytes arrive from the command decoder as plain ports.
`ifndef OVUV_REACTION_REGS_VH
`define OVUV_REACTION_REGS_VH

// ****************************************
// Reaction configuration byte fields
// ****************************************
`define ACT_HI 7
`define ACT_LO 6
`define RETRY_HI 5
`define RETRY_LO 3
`define DEGL_HI 2
`define DEGL_LO 0
`define ACT_CONTINUE 2'h0
`define ACT_DEGLITCH 2'h1
`define RETRY_NONE 3'h0
`define DEGL_NONE 3'h0

// ****************************************
// Status bit positions
// ****************************************
`define VOUT_OV_FAULT_BIT 7
`define VOUT_UV_FAULT_BIT 4
`define STATUS_VOUT_RESET 8'h00

// ****************************************
// Timing
// ****************************************
`define CLK_HZ 50000000
`define SAMPLE_PERIOD_NS 12200
`define TOFF_MAX_MS 16'h332c

`endif

// *** output_voltage_fault_reaction.v ***
// Fault reaction for the eight fast output voltage supervisors.
// Assumes comparator trips and on/off requests arrive from outside the CLK domain and
// are synchronised here; config and the per-channel clear pulse come from CLK logic.
// What this block does
// - OV fault sets byte summary; any fault sets word and vout bits
// - Fault pulls the active-low alert line low
// - Odd current-sense channels ignore OV/UV entirely
// - Action 00b keeps channel running
// - Action 01b shuts down if fault persists
// - Action 1Xb shuts down, immediate or sequenced
// - After shutdown apply retry field policy
// - Retry 000b stays off until cleared
// - Retry nonzero restarts up to global limit
// - Restarts stop on command off or fault
// - Deglitch field counts ignored supervisor samples
// - Deglitch 000b turns off immediately
// - Deglitch 1-7 turns off after samples
// - Sequenced off waits turn-off delay, capped
`timescale 1ns/1ps
`include "ovuv_reaction_regs.vh"

module output_voltage_fault_reaction #(
    parameter CHANNELS = 8,
    parameter SAMPLE_CYCLES = (`SAMPLE_PERIOD_NS * (`CLK_HZ / 1000000)) / 1000,
    parameter TOFF_UNIT_CYCLES = `CLK_HZ / 1000
)(
    // Clock and reset
    input wire CLK,
    input wire RESET,
    // Supervisor comparator trips, one bit per channel
    input wire [7:0] OV_TRIP,
    input wire [7:0] UV_TRIP,
    // Channel control
    input wire [7:0] CHAN_ON_PIN,
    input wire [7:0] CHAN_ON_CMD,
    input wire [7:0] CURRENT_MODE,
    input wire [7:0] SEQ_OFF_MODE,
    input wire [7:0] STATUS_CLEAR,
    // Configuration: one byte per channel per reaction, plus global retry limit and turn-off delay
    input wire [63:0] OV_REACTION_CFG,
    input wire [63:0] UV_REACTION_CFG,
    input wire [2:0] RETRY_LIMIT,
    input wire [15:0] TOFF_DELAY_MS,
    // Outputs
    output reg [7:0] CHAN_ENABLE,
    output reg [63:0] STATUS_VOUT,
    output reg STATUS_BYTE_VOUT_OV,
    output reg STATUS_WORD_VOUT,
    output reg ALERT_LINE_N
);

    // ****************************************
    // Channel states
    // ****************************************
    // RUN: converter enabled and supervised.
    // SEQ: shutdown decided, enable held until the turn-off wait runs out.
    // OFF: converter disabled after a fault, waiting for a retry or a clear.
    // IDLE: commanded off; also the state after reset.
    localparam ST_RUN = 2'h0;
    localparam ST_SEQ = 2'h1;
    localparam ST_OFF = 2'h2;
    localparam ST_IDLE = 2'h3;

    // ****************************************
    // Input synchronisers
    // ****************************************
    reg [7:0] ov_s1_r, ov_s2_r, uv_s1_r, uv_s2_r, pin_s1_r, pin_s2_r, cmd_s1_r, cmd_s2_r;
    always @(posedge CLK)
    begin
        ov_s1_r <= OV_TRIP;
        ov_s2_r <= ov_s1_r;
        uv_s1_r <= UV_TRIP;
        uv_s2_r <= uv_s1_r;
        pin_s1_r <= CHAN_ON_PIN;
        pin_s2_r <= pin_s1_r;
        cmd_s1_r <= CHAN_ON_CMD;
        cmd_s2_r <= cmd_s1_r;
    end

    // ****************************************
    // Supervisor sample tick
    // ****************************************
    reg [15:0] samp_cnt_r;
    reg samp_tick_r;
    // Toff unit tick, one per millisecond
    reg [31:0] ms_cnt_r;
    reg ms_tick_r;
    always @(posedge CLK)
    begin
        if (RESET)
        begin
            samp_cnt_r <= 16'h0000;
            samp_tick_r <= 1'b0;
            ms_cnt_r <= 32'h00000000;
            ms_tick_r <= 1'b0;
        end
        else
        begin
            samp_tick_r <= (samp_cnt_r == SAMPLE_CYCLES[15:0] - 16'h0001);
            samp_cnt_r <= (samp_cnt_r == SAMPLE_CYCLES[15:0] - 16'h0001) ? 16'h0000
                : samp_cnt_r + 16'h0001;
            ms_tick_r <= (ms_cnt_r == TOFF_UNIT_CYCLES - 1);
            ms_cnt_r <= (ms_cnt_r == TOFF_UNIT_CYCLES - 1) ? 32'h00000000
                : ms_cnt_r + 32'h00000001;
        end
    end

    // ****************************************
    // Turn-off delay clamp
    // ****************************************
    // clamp the turn-off wait to its ceiling
    wire [15:0] toff_lim = (TOFF_DELAY_MS > `TOFF_MAX_MS) ? `TOFF_MAX_MS : TOFF_DELAY_MS;

    wire [7:0] any_fault;
    wire [7:0] vout_new;

    // ****************************************
    // Per-channel reaction
    // ****************************************
    // Each channel keeps its own deglitch counters, retry count and turn-off
    // counter, so a fault on one rail never disturbs the timing of another.
    // The retry count is set to 7 when retries run out or the retry field is 000b, which marks a channel that must not
    // restart again until a clear arrives with the fault gone.
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1)
        begin : chan
            wire [7:0] ovc = OV_REACTION_CFG[g*8 +: 8];
            wire [7:0] uvc = UV_REACTION_CFG[g*8 +: 8];
            // only odd channels can be in current mode
            wire muted = CURRENT_MODE[g] && (g % 2 == 1);
            wire ov = ov_s2_r[g] && !muted;
            wire uv = uv_s2_r[g] && !muted;
            wire on_req = pin_s2_r[g] && cmd_s2_r[g];
            reg [2:0] ov_cnt_r, uv_cnt_r;
            reg [1:0] st_r;
            reg [2:0] tries_r;
            reg [15:0] toff_cnt_r;
            reg [7:0] stat_r;
            reg ov_shut, uv_shut;
            // each reaction has its own counter and byte
            always @*
            begin
                ov_shut = 1'b0;
                uv_shut = 1'b0;
                if (ov && ovc[`ACT_HI:`ACT_LO] != `ACT_CONTINUE)
                    // zero deglitch or action 1Xb shuts at once
                    ov_shut = ovc[`ACT_HI] || ovc[`DEGL_HI:`DEGL_LO] == `DEGL_NONE ||
                        (samp_tick_r && ov_cnt_r + 3'h1 >= ovc[`DEGL_HI:`DEGL_LO]);
                if (uv && uvc[`ACT_HI:`ACT_LO] != `ACT_CONTINUE)
                    uv_shut = uvc[`ACT_HI] || uvc[`DEGL_HI:`DEGL_LO] == `DEGL_NONE ||
                        (samp_tick_r && uv_cnt_r + 3'h1 >= uvc[`DEGL_HI:`DEGL_LO]);
            end
            wire shut = (ov_shut || uv_shut) && (st_r == ST_RUN);
            wire [2:0] retry_f = ov_shut ? ovc[`RETRY_HI:`RETRY_LO] : uvc[`RETRY_HI:`RETRY_LO];
            // style chooses sequenced or immediate off
            wire seq = (ov_shut ? ovc[`ACT_HI:`ACT_LO] : uvc[`ACT_HI:`ACT_LO]) != 2'h0
                && SEQ_OFF_MODE[g];
            assign any_fault[g] = ov || uv;
            // Live overvoltage, so the OV summary rises before the sticky bit lands
            assign vout_new[g] = ov;
            always @(posedge CLK)
            begin
                if (RESET)
                begin
                    ov_cnt_r <= 3'h0;
                    uv_cnt_r <= 3'h0;
                    st_r <= ST_IDLE;
                    tries_r <= 3'h0;
                    toff_cnt_r <= 16'h0000;
                    stat_r <= `STATUS_VOUT_RESET;
                end
                else
                begin
                    // Counters saturate at 7: the deglitch field cannot ask for more,
                    // and a wrap would restart the ignore window of a lasting fault.
                    // count samples while the fault persists
                    // fault gone before expiry resets the count
                    if (!ov)
                        ov_cnt_r <= 3'h0;
                    else if (samp_tick_r && ov_cnt_r != 3'h7)
                        ov_cnt_r <= ov_cnt_r + 3'h1;
                    if (!uv)
                        uv_cnt_r <= 3'h0;
                    else if (samp_tick_r && uv_cnt_r != 3'h7)
                        uv_cnt_r <= uv_cnt_r + 3'h1;
                    // set wins over a clear in the same cycle
                    stat_r[`VOUT_OV_FAULT_BIT] <= ov ||
                        (stat_r[`VOUT_OV_FAULT_BIT] && !STATUS_CLEAR[g]);
                    stat_r[`VOUT_UV_FAULT_BIT] <= uv ||
                        (stat_r[`VOUT_UV_FAULT_BIT] && !STATUS_CLEAR[g]);
                    case (st_r)
                        ST_IDLE:
                        begin
                            tries_r <= 3'h0;
                            if (on_req)
                                st_r <= ST_RUN;
                        end
                        ST_RUN:
                        begin
                            if (!on_req)
                                st_r <= ST_IDLE;
                            else if (shut)
                            begin
                                if (retry_f != `RETRY_NONE && tries_r < RETRY_LIMIT)
                                    tries_r <= tries_r + 3'h1;
                                else
                                    tries_r <= 3'h7;
                                toff_cnt_r <= toff_lim;
                                st_r <= seq ? ST_SEQ : ST_OFF;
                            end
                        end
                        ST_SEQ:
                        begin
                            if (toff_cnt_r == 16'h0000)
                                st_r <= ST_OFF;
                            else if (ms_tick_r)
                                toff_cnt_r <= toff_cnt_r - 16'h0001;
                        end
                        default:
                        begin
                            // A restart is only tried once both comparators are quiet;
                            // restarting into a standing fault would just trip again.
                            // commanded off ends retries
                            if (!on_req)
                                st_r <= ST_IDLE;
                            // no restart while the fault stands
                            // restart only within the global count
                            else if (!(ov || uv) && tries_r != 3'h7 && tries_r <= RETRY_LIMIT
                                && !(stat_r != 8'h00 && tries_r == 3'h0))
                                st_r <= ST_RUN;
                            else if (!(ov || uv) && STATUS_CLEAR[g])
                            begin
                                tries_r <= 3'h0;
                                st_r <= ST_RUN;
                            end
                        end
                    endcase
                end
            end
            // Immediate shutdown drops the enable in the same cycle as the state change,
            // one clock earlier than waiting for the OFF state to reach the output.
            always @(posedge CLK)
            begin
                if (RESET)
                begin
                    CHAN_ENABLE[g] <= 1'b0;
                    STATUS_VOUT[g*8 +: 8] <= `STATUS_VOUT_RESET;
                end
                else
                begin
                    CHAN_ENABLE[g] <= (st_r == ST_RUN || st_r == ST_SEQ) && !(shut && !seq);
                    STATUS_VOUT[g*8 +: 8] <= stat_r;
                end
            end
        end
    endgenerate

    // ****************************************
    // Summary status and alert
    // ****************************************
    // Summaries read the registered status, so they trail the channel bits
    // by one clock; live faults are added so the alert is not delayed further.
    reg [7:0] sum_r;
    reg [7:0] ov_sum_r;
    integer i;
    always @*
    begin
        sum_r = 8'h00;
        ov_sum_r = 8'h00;
        for (i = 0; i < CHANNELS; i = i + 1)
        begin
            ov_sum_r[i] = STATUS_VOUT[i*8 + `VOUT_OV_FAULT_BIT];
            sum_r[i] = ov_sum_r[i] | STATUS_VOUT[i*8 + `VOUT_UV_FAULT_BIT];
        end
    end

    always @(posedge CLK)
    begin
        if (RESET)
        begin
            STATUS_BYTE_VOUT_OV <= 1'b0;
            STATUS_WORD_VOUT <= 1'b0;
            ALERT_LINE_N <= 1'b1;
        end
        else
        begin
            // summary bits follow the sticky channel bits
            STATUS_BYTE_VOUT_OV <= |ov_sum_r || |vout_new;
            STATUS_WORD_VOUT <= |sum_r || |any_fault;
            // alert held low while any flag stands
            ALERT_LINE_N <= !(|sum_r || |any_fault);
        end
    end

endmodule // output_voltage_fault_reaction

// *** ovuv_reaction_props.sv ***
// Checker for the output voltage fault reaction block.
// Sees only the top module ports; bound to every instance below.
`timescale 1ns/1ps
module ovuv_reaction_props (
    // Clock and reset
    input wire CLK,
    input wire RESET,
    // Inputs watched
    input wire [7:0] UV_TRIP,
    input wire [7:0] CHAN_ON_PIN,
    input wire [7:0] CHAN_ON_CMD,
    input wire [7:0] CURRENT_MODE,
    input wire [7:0] SEQ_OFF_MODE,
    input wire [7:0] STATUS_CLEAR,
    input wire [63:0] OV_REACTION_CFG,
    input wire [63:0] UV_REACTION_CFG,
    // Outputs watched
    input wire [7:0] CHAN_ENABLE,
    input wire [63:0] STATUS_VOUT,
    input wire STATUS_BYTE_VOUT_OV,
    input wire STATUS_WORD_VOUT,
    input wire ALERT_LINE_N
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    // ****************************************
    // Properties
    // ****************************************
    chk_alert_on_flag: assert property ((STATUS_VOUT != 64'h0) |-> ##[0:2] !ALERT_LINE_N)
        else $error("alert line not low with a flag set");
    chk_word_summary: assert property ((STATUS_VOUT != 64'h0) |-> ##[0:2] STATUS_WORD_VOUT)
        else $error("status word summary missing");
    chk_ov_summary: assert property (STATUS_VOUT[7] |-> ##[0:2] STATUS_BYTE_VOUT_OV)
        else $error("status byte summary missing");
    chk_status_sticky: assert property (
        (STATUS_VOUT[7] && !STATUS_CLEAR[0]) [*6] |=> STATUS_VOUT[7])
        else $error("fault flag dropped without clear");
    chk_muted_quiet: assert property (
        CURRENT_MODE[1] [*8] |-> !$rose(STATUS_VOUT[15] | STATUS_VOUT[12]))
        else $error("muted channel raised a flag");
    chk_continue_runs: assert property (
        (CHAN_ENABLE[0] && CHAN_ON_PIN[0] && CHAN_ON_CMD[0]
        && OV_REACTION_CFG[7:6] == 2'h0 && UV_REACTION_CFG[7:6] == 2'h0) [*8]
        |=> CHAN_ENABLE[0])
        else $error("continue action stopped the channel");
    chk_immediate_off: assert property (
        (UV_TRIP[2] && UV_REACTION_CFG[23] && UV_REACTION_CFG[21:16] == 6'h0
        && !SEQ_OFF_MODE[2]) [*8] |-> !CHAN_ENABLE[2])
        else $error("shutdown action left channel on");
    chk_cmd_off: assert property ((!CHAN_ON_PIN[0] && !SEQ_OFF_MODE[0]) [*8] |-> !CHAN_ENABLE[0])
        else $error("channel on while commanded off");
endmodule // ovuv_reaction_props
bind output_voltage_fault_reaction ovuv_reaction_props u_ovuv_reaction_props (.CLK, .RESET, .UV_TRIP,
    .CHAN_ON_PIN, .CHAN_ON_CMD, .CURRENT_MODE, .SEQ_OFF_MODE, .STATUS_CLEAR, .OV_REACTION_CFG,
    .UV_REACTION_CFG, .CHAN_ENABLE, .STATUS_VOUT, .STATUS_BYTE_VOUT_OV, .STATUS_WORD_VOUT, .ALERT_LINE_N);

// *** converter_model.sv ***
// Model of the eight supervised converters and their comparators.
// Assumes the bench asks for faults; the enables come from the block.
`timescale 1ns/1ps
module converter_model (
    // Block side
    input wire [7:0] enable,
    output wire [7:0] ov_trip,
    output wire [7:0] uv_trip,
    // Bench side
    input wire [7:0] force_ov,
    input wire [7:0] force_uv
);
    // A rail that is switched off cannot overshoot, so OV follows enable
    assign ov_trip = force_ov & enable;
    assign uv_trip = force_uv;
endmodule // converter_model

// *** tb.sv ***
// Self-checking bench for the output voltage fault reaction block.
// Assumes short sample and turn-off units so the run stays brief.
`timescale 1ns/1ps
module tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [7:0] pin = 8'hff, cmd = 8'hff, cur = 8'haa, seqm = 8'h00, clr = 8'h00;
    reg [7:0] ov_f = 8'h00, uv_f = 8'h00, rnd = 8'h05;
    reg [63:0] ov_cfg = 64'h8000_8000_8000_8000, uv_cfg = 64'h8088_8043_8080_8000;
    wire [7:0] en, ov_t, uv_t;
    wire [63:0] st;
    wire sb, sw, al;
    integer err_count = 0, n_compared = 0, cyc = 0, k;
    reg [65:0] exp_q[$];
    reg [65:0] e;
    event look;
    initial
    begin
        forever
            #10 clk = ~clk;
    end
    output_voltage_fault_reaction #(.SAMPLE_CYCLES(4), .TOFF_UNIT_CYCLES(10)) u_output_voltage_fault_reaction (
        .CLK(clk), .RESET(rst), .OV_TRIP(ov_t), .UV_TRIP(uv_t), .CHAN_ON_PIN(pin), .CHAN_ON_CMD(cmd),
        .CURRENT_MODE(cur), .SEQ_OFF_MODE(seqm), .STATUS_CLEAR(clr), .OV_REACTION_CFG(ov_cfg),
        .UV_REACTION_CFG(uv_cfg), .RETRY_LIMIT(3'h2), .TOFF_DELAY_MS(16'h0001), .CHAN_ENABLE(en),
        .STATUS_VOUT(st), .STATUS_BYTE_VOUT_OV(sb), .STATUS_WORD_VOUT(sw), .ALERT_LINE_N(al));
    converter_model u_converter_model (.enable(en), .ov_trip(ov_t), .uv_trip(uv_t),
        .force_ov(ov_f), .force_uv(uv_f));
    // ****************************************
    // Helpers
    // ****************************************
    function [7:0] lfsr(input [7:0] v);
        lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // Kind 0 enables, 1 status bytes, 2 word, byte, alert
    task note(input [1:0] k, input [63:0] v);
        begin
            @(negedge clk);
            exp_q.push_back({k, v});
            -> look;
        end
    endtask
    task cmp(input [63:0] got, input [63:0] want);
        begin
            n_compared = n_compared + 1;
            if (got !== want)
            begin
                err_count = err_count + 1;
                $display("BAD t=%0t got %h exp %h", $time, got, want);
            end
        end
    endtask
    task test_done;
        begin
            $display("compared %0d mismatches %0d", n_compared, err_count);
            if (err_count == 0 && n_compared > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial
    begin
        forever
        begin
            @(look);
            e = exp_q.pop_front();
            if (e[65:64] == 2'h0)
                cmp({56'h0, en}, e[63:0]);
            else if (e[65:64] == 2'h1)
                cmp(st, e[63:0]);
            else
                cmp({61'h0, sw, sb, al}, e[63:0]);
        end
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_count = err_count + 1;
            test_done;
        end
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        tick(10);
        note(2'h1, 64'h0);
        note(2'h2, 64'h1);
        tick(1);
        rst <= 1'b0;
        tick(20);
        note(2'h0, 64'hff);
        // Continue action on ch0 while muted odd channels see noise
        ov_f <= 8'h01;
        repeat (10)
        begin
            @(posedge clk);
            rnd = lfsr(rnd);
            uv_f <= rnd & 8'haa;
        end
        note(2'h0, 64'hff);
        note(2'h1, 64'h80);
        note(2'h2, 64'h6);
        tick(1);
        ov_f <= 8'h00;
        uv_f <= 8'h00;
        tick(8);
        clr <= 8'h01;
        tick(1);
        clr <= 8'h00;
        tick(10);
        note(2'h2, 64'h1);
        // Shutdown action, no deglitch, no retry on ch2
        tick(1);
        uv_f <= 8'h04;
        tick(10);
        note(2'h0, 64'hfb);
        note(2'h1, 64'h10_0000);
        tick(1);
        uv_f <= 8'h00;
        tick(20);
        note(2'h0, 64'hfb);
        // Deglitch of three samples on ch4: short glitch, then a lasting fault
        tick(1);
        uv_f <= 8'h10;
        tick(3);
        uv_f <= 8'h00;
        tick(10);
        note(2'h0, 64'hfb);
        tick(1);
        uv_f <= 8'h10;
        tick(40);
        note(2'h0, 64'heb);
        // Sequenced off on ch6: two restarts allowed, the third fault stays off
        tick(1);
        seqm <= 8'h40;
        for (k = 0; k < 3; k = k + 1)
        begin
            tick(1);
            uv_f <= 8'h40;
            tick(4);
            note(2'h0, 64'heb);
            tick(30);
            note(2'h0, 64'hab);
            tick(1);
            uv_f <= 8'h00;
            tick(10);
            note(2'h0, (k < 2) ? 64'heb : 64'hab);
        end
        tick(1);
        pin <= 8'hfe;
        tick(12);
        note(2'h0, 64'haa);
        tick(2);
        test_done;
    end
endmodule // tb
